// ===== inc/acd_params.svh
// Purpose: Offsets, field positions, reset values and timing counts for the converter control.
// Assumes: Included by bare name; definitions only.
// Notes: Register indices sit on word boundaries of the local register port.
`ifndef ACD_PARAMS_SVH
`define ACD_PARAMS_SVH
`define ACD_NUM_LINES 4
`define ACD_DIV_LSB 0
`define ACD_DIV_MSB 3
`define ACD_CTL2_RESET 16'h0000
`define ACD_ADDR_FLAG 8'h00
`define ACD_ADDR_CLR 8'h04
`define ACD_ADDR_OVF 8'h08
`define ACD_ADDR_CONT 8'h0c
`define ACD_ADDR_CTL2 8'h10
`define ACD_ADDR_RESULT 8'h14
`define ACD_ADDR_LATE 8'h18
`define ACD_ADDR_STAT 8'h40
`define ACD_ADDR_MASK 8'h44
`define ACD_ADDR_CMD 8'h48
`define ACD_ADDR_ORDER 8'h4c
`define ACD_ADDR_RD 8'h50
`define ACD_LAT_DELAY_LONG 3'd3
`define ACD_LAT_DELAY_SHORT 3'd1
`define ACD_LATE_DIV_LIMIT 4'h2
`define ACD_SAMPLE_CYCLES 6'd20
`endif

// ===== inc/acd_pkg.sv
// Purpose: Types shared by both ends of the converter control link.
// Assumes: Used together with acd_params.svh.
// Notes: Register port is a simple single-cycle strobe port.
package acd_pkg;
	typedef logic [7:0] acd_addr_t;
	typedef logic [15:0] acd_data_t;
	typedef enum logic [1:0] {ACD_ST_IDLE, ACD_ST_ADDR, ACD_ST_DATA} acd_bus_state_t;
	typedef enum logic [1:0] {ACD_RD_IDLE, ACD_RD_DUMMY, ACD_RD_RESULT} acd_rd_state_t;
endpackage : acd_pkg

// ===== inc/acd_if.sv
// Purpose: Link between the converter control device and the reading controller.
// Assumes: One clock, ref_clk, shared by both ends.
// Notes: Reads answer in the cycle after the strobe.
`timescale 1ns/1ns
interface acd_if;
	logic [3:0] conversion_interrupt;
	logic wr_en;
	logic rd_en;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic rvalid;
	modport device (output conversion_interrupt, input wr_en, input rd_en, input addr,
		input wdata, output rdata, output rvalid);
	modport reader (input conversion_interrupt, output wr_en, output rd_en, output addr,
		output wdata, input rdata, input rvalid);
endinterface : acd_if

// ===== hw/acd_device.sv
// Purpose: Interrupt flags, overflow, clock divider and result latch of the converter.
// Assumes: Register port strobes are synchronous to ref_clk and single cycle.
// Notes: The converter clock is a scaled model of the divider, one base step per ref_clk.
`timescale 1ns/1ns
`include "acd_params.svh"
module acd_device (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Converter side.
	input wire logic [3:0] eoc_event,
	input wire logic [11:0] sample_data,
	output logic converter_clock,
	// Link to the reader.
	acd_if.device link
);
	import acd_pkg::*;

	// Per-line interrupt state.
	logic [3:0] conversion_interrupt_flag;
	logic [3:0] interrupt_overflow_flag;
	logic [3:0] continue_interrupt_bit;
	logic [3:0] int_fire;
	logic [3:0] clr_mask;
	logic clr_write;
	// Control registers.
	logic [15:0] converter_control_second;
	logic late_mode;
	// Result path.
	logic [15:0] conversion_result_reg;
	logic [11:0] pend_data;
	logic [2:0] lat_cnt;
	// Divider.
	logic [3:0] div_code;
	logic [4:0] phase;
	logic [4:0] period_last;
	logic [4:0] high_len;

	// The divider code is the low field of the second control register.
	assign div_code = converter_control_second[`ACD_DIV_MSB:`ACD_DIV_LSB];
	// Only ones in a clear write act; zeros leave their lines alone.
	assign clr_write = link.wr_en && link.addr == `ACD_ADDR_CLR;
	assign clr_mask = clr_write ? link.wdata[3:0] : 4'h0;

	// An event fires an interrupt unless a non-continue line already holds its flag.
	// The decision looks at the flag as it stands before this edge, so a flag that
	// is being cleared on this very edge still blocks the event that meets it.
	genvar gi;
	generate
		for (gi = 0; gi < `ACD_NUM_LINES; gi++) begin : g_line
			assign int_fire[gi] = eoc_event[gi] &&
				(continue_interrupt_bit[gi] || !conversion_interrupt_flag[gi]);
			// Set beats a coincident clear, so the flag stays up; software that
			// races a conversion must read overflow and clear a second time.
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					conversion_interrupt_flag[gi] <= 1'b0;
				end else if (clk_en) begin
					if (eoc_event[gi]) begin
						conversion_interrupt_flag[gi] <= 1'b1;
					end else if (clr_mask[gi]) begin
						conversion_interrupt_flag[gi] <= 1'b0;
					end
				end
			end
			// Overflow marks an event that met a raised flag; on a non-continue line that is a lost interrupt.
			// It clears with the flag, and an event on the clear edge wins here too.
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					interrupt_overflow_flag[gi] <= 1'b0;
				end else if (clk_en) begin
					if (eoc_event[gi] && conversion_interrupt_flag[gi]) begin
						interrupt_overflow_flag[gi] <= 1'b1;
					end else if (clr_mask[gi]) begin
						interrupt_overflow_flag[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Interrupt pulses go out registered, one cycle per accepted event.
	// The pulse leaves on the same edge that raises the flag, so a reader that
	// polls the flag and one that waits for the pulse see the event together.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			link.conversion_interrupt <= 4'h0;
		end else if (clk_en) begin
			link.conversion_interrupt <= int_fire;
		end
	end

	// Control registers written by the reader.
	// Writes land on the strobe edge; a read in the next cycle already shows them.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			continue_interrupt_bit <= 4'h0;
			converter_control_second <= `ACD_CTL2_RESET;
			late_mode <= 1'b0;
		end else if (clk_en && link.wr_en) begin
			case (link.addr)
				`ACD_ADDR_CONT: continue_interrupt_bit <= link.wdata[3:0];
				`ACD_ADDR_CTL2: converter_control_second <= link.wdata;
				`ACD_ADDR_LATE: late_mode <= link.wdata[0];
				default: ;
			endcase
		end
	end

	// The converter clock period is the code plus two ref_clk cycles, so against a
	// base period of two cycles the ratio is (code+2)/2: 1.0, 1.5, 2.0, 2.5 and on.
	// Odd codes give an uneven duty cycle, which is why they degrade conversions.
	// The rising edge starts each period; the falling edge sits at its middle.
	assign period_last = 5'(div_code) + 5'd1;
	assign high_len = (5'(div_code) + 5'd2) >> 1;
	// A new code acts at once: a phase past the new period wraps on the next edge.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 5'd0;
			converter_clock <= 1'b0;
		end else if (clk_en) begin
			if (phase >= period_last) begin
				phase <= 5'd0;
				converter_clock <= 1'b1;
			end else begin
				phase <= phase + 5'd1;
				if (phase + 5'd1 == high_len) begin
					converter_clock <= 1'b0;
				end
			end
		end
	end

	// Sample data is held from the event until the latch point.
	// A new event simply replaces it; a conversion that is still pending is lost.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_data <= 12'h000;
		end else if (clk_en && |eoc_event) begin
			pend_data <= sample_data;
		end
	end

	// Result latches after the interrupt; in late mode with a slow divider the
	// pulse leads the latch by three cycles, so an immediate read sees the
	// previous value, while a read that waits past one dummy access is current.
	// A quick latch otherwise keeps interrupt handlers and polling loops safe.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lat_cnt <= 3'd0;
			conversion_result_reg <= 16'h0000;
		end else if (clk_en) begin
			if (|eoc_event) begin
				if (late_mode && div_code > `ACD_LATE_DIV_LIMIT) begin
					lat_cnt <= `ACD_LAT_DELAY_LONG;
				end else begin
					lat_cnt <= `ACD_LAT_DELAY_SHORT;
				end
			end else if (lat_cnt != 3'd0) begin
				lat_cnt <= lat_cnt - 3'd1;
				if (lat_cnt == 3'd1) begin
					conversion_result_reg <= {4'h0, pend_data};
				end
			end
		end
	end

	// Read data is registered and valid one cycle after the strobe; clear reads zero.
	// Data is loaded only on a read strobe, so it stands until the next read and a
	// reader may take it late without seeing a later address leak in.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			link.rdata <= 16'h0000;
			link.rvalid <= 1'b0;
		end else if (clk_en) begin
			link.rvalid <= link.rd_en;
			if (link.rd_en) begin
				case (link.addr)
					`ACD_ADDR_FLAG: link.rdata <= {12'h000, conversion_interrupt_flag};
					`ACD_ADDR_OVF: link.rdata <= {12'h000, interrupt_overflow_flag};
					`ACD_ADDR_CONT: link.rdata <= {12'h000, continue_interrupt_bit};
					`ACD_ADDR_CTL2: link.rdata <= converter_control_second;
					`ACD_ADDR_RESULT: link.rdata <= conversion_result_reg;
					`ACD_ADDR_LATE: link.rdata <= {15'h0000, late_mode};
					default: link.rdata <= 16'h0000;
				endcase
			end
		end
	end
endmodule : acd_device

// ===== hw/acd_reader.sv
// Purpose: Controller that reads conversion results, reached by software over AHB-Lite.
// Assumes: Single-word transfers; hready of the bus equals this slave's hreadyout.
// Notes: Software commands link accesses; interrupts report completions and flags.
`timescale 1ns/1ns
`include "acd_params.svh"
module acd_reader (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Interrupt.
	output logic irq,
	// Link to the device.
	acd_if.reader link
);
	import acd_pkg::*;

	logic ph_valid;
	logic ph_write;
	logic [7:0] ph_addr;
	logic [3:0] status;
	logic [3:0] mask;
	logic [3:0] ev;
	logic [31:0] cmd;
	logic dual_order;
	logic [15:0] rd_data;
	logic cmd_go;
	logic busy;
	acd_rd_state_t st;
	logic auto_go;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq = |(status & mask);

	// Address phase capture.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr <= 8'h00;
		end else if (clk_en && hready) begin
			ph_valid <= hsel && htrans[1];
			ph_write <= hwrite;
			ph_addr <= haddr[7:0];
		end
	end

	assign cmd_go = clk_en && ph_valid && ph_write && ph_addr == `ACD_ADDR_CMD && !busy;
	assign auto_go = clk_en && |link.conversion_interrupt && !busy;

	// Software registers.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask <= 4'h0;
			cmd <= 32'h00000000;
			dual_order <= 1'b1;
		end else if (clk_en && ph_valid && ph_write) begin
			case (ph_addr)
				`ACD_ADDR_MASK: mask <= hwdata[3:0];
				`ACD_ADDR_CMD: cmd <= hwdata;
				`ACD_ADDR_ORDER: dual_order <= hwdata[0];
				default: ;
			endcase
		end
	end

	// Event bits: 0 read done, 1 interrupt seen. Set wins over write-one clear.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			status <= 4'h0;
		end else if (clk_en) begin
			status <= (status & ~((ph_valid && ph_write && ph_addr == `ACD_ADDR_STAT) ?
				hwdata[3:0] : 4'h0)) | ev;
		end
	end

	// Read sequencer: on an interrupt, a dummy read precedes the result read so
	// the result has latched by then; a software command drives one access and wins over a coincident interrupt.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= ACD_RD_IDLE;
			busy <= 1'b0;
			rd_data <= 16'h0000;
			link.wr_en <= 1'b0;
			link.rd_en <= 1'b0;
			link.addr <= 8'h00;
			link.wdata <= 16'h0000;
			ev <= 4'h0;
		end else if (clk_en) begin
			link.wr_en <= 1'b0;
			link.rd_en <= 1'b0;
			ev <= {3'h0, 1'b0};
			case (st)
				ACD_RD_IDLE: begin
					if (cmd_go) begin
						link.wr_en <= hwdata[31];
						link.rd_en <= ~hwdata[31];
						link.addr <= hwdata[23:16];
						link.wdata <= hwdata[15:0];
						busy <= ~hwdata[31];
						st <= hwdata[31] ? ACD_RD_IDLE : ACD_RD_RESULT;
					end else if (auto_go) begin
						ev[1] <= 1'b1;
						link.rd_en <= 1'b1;
						link.addr <= dual_order ? `ACD_ADDR_FLAG : `ACD_ADDR_RESULT;
						busy <= 1'b1;
						st <= dual_order ? ACD_RD_DUMMY : ACD_RD_RESULT;
					end
				end
				ACD_RD_DUMMY: begin
					if (link.rvalid) begin
						link.rd_en <= 1'b1;
						link.addr <= `ACD_ADDR_RESULT;
						st <= ACD_RD_RESULT;
					end
				end
				ACD_RD_RESULT: begin
					if (link.rvalid) begin
						rd_data <= link.rdata;
						ev[0] <= 1'b1;
						busy <= 1'b0;
						st <= ACD_RD_IDLE;
					end
				end
				default: st <= ACD_RD_IDLE;
			endcase
		end
	end

	// Read data mux.
	always_comb begin
		hrdata = 32'h00000000;
		if (ph_valid && !ph_write) begin
			case (ph_addr)
				`ACD_ADDR_STAT: hrdata = {28'h0000000, status};
				`ACD_ADDR_MASK: hrdata = {28'h0000000, mask};
				`ACD_ADDR_CMD: hrdata = {cmd[31:1], busy};
				`ACD_ADDR_ORDER: hrdata = {31'h00000000, dual_order};
				`ACD_ADDR_RD: hrdata = {16'h0000, rd_data};
				default: hrdata = 32'h00000000;
			endcase
		end
	end
endmodule : acd_reader

// ===== dv/acd_assertions.sv
// Purpose: Link checks between the converter device and the reader.
// Assumes: clk_en held high on both ends.
// Notes: Shadows follow writes and pulses seen on the link.
`timescale 1ns/1ns
`include "acd_params.svh"
module acd_assertions (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Link signals.
	input wire logic [3:0] conversion_interrupt,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic rvalid
);
	logic [3:0] cont;
	logic [3:0] div;
	logic [3:0] blk;
	logic [3:0] seen;
	logic [3:0] clr;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// A clear write lands on the same edge as the pulse it may race.
	assign clr = (wr_en && addr == `ACD_ADDR_CLR) ? wdata[3:0] : 4'h0;
	// Shadows only underestimate the flags, so they never fire falsely.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cont <= 4'h0;
			div <= 4'h0;
			blk <= 4'h0;
			seen <= 4'h0;
		end else begin
			if (wr_en && addr == `ACD_ADDR_CONT)
				cont <= wdata[3:0];
			if (wr_en && addr == `ACD_ADDR_CTL2)
				div <= wdata[3:0];
			blk <= (blk | (conversion_interrupt & ~cont)) & ~clr;
			seen <= (seen | conversion_interrupt) & ~clr;
		end
	end
	a_read_answer_next: assert property (rd_en |=> rvalid)
		else $error("read not answered next cycle");
	a_answer_has_cause: assert property (rvalid |-> $past(rd_en))
		else $error("answer without read");
	a_clear_reads_zero: assert property (
		rd_en && addr == `ACD_ADDR_CLR |=> rdata == 16'h0000)
		else $error("clear register not zero");
	a_unmapped_reads_zero: assert property (rd_en && addr == 8'h20 |=> rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_noncont_blocks: assert property ((conversion_interrupt & blk & ~cont) == 4'h0)
		else $error("interrupt while flag set");
	a_cont_kept: assert property (
		rd_en && addr == `ACD_ADDR_CONT |=> rdata[3:0] == $past(cont))
		else $error("continue bits lost");
	a_divider_kept: assert property (
		rd_en && addr == `ACD_ADDR_CTL2 |=> rdata[3:0] == $past(div))
		else $error("divider code lost");
	a_flag_seen_set: assert property (
		rd_en && addr == `ACD_ADDR_FLAG |=> (rdata[3:0] & $past(seen)) == $past(seen))
		else $error("flag clear after interrupt");
endmodule : acd_assertions

// ===== dv/acd_tb_top.sv
// Purpose: Drives software over AHB-Lite and conversion events.
// Assumes: Reader command bit 31 high means write.
// Notes: Random sample data uses a fixed seed; event lines are stepped in order.
`timescale 1ns/1ns
`include "acd_params.svh"
module acd_tb_top;
	logic ref_clk, rst_n, hwrite, irq, hreadyout, hresp, cclk;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [3:0] eoc_event;
	logic [11:0] sample_data;
	int err_total, check_count, pc;
	acd_if link ();
	acd_device acd_device_inst (.ref_clk, .rst_n, .clk_en(1'b1), .eoc_event, .sample_data,
		.converter_clock(cclk), .link(link));
	acd_reader acd_reader_inst (.ref_clk, .rst_n, .clk_en(1'b1), .hsel(1'b1), .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
		.hresp, .irq, .link(link));
	acd_assertions acd_assertions_inst (.ref_clk, .rst_n,
		.conversion_interrupt(link.conversion_interrupt), .wr_en(link.wr_en),
		.rd_en(link.rd_en), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
		.rvalid(link.rvalid));
	// Free-running clock.
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Pulse counter, sampled before the edge's own updates.
	always @(posedge ref_clk) begin
		pc += $countones(link.conversion_interrupt);
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk
	// One single-word transfer; waits on hready, never on a cycle count.
	task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : ahb
	// Device access through the reader's command register.
	task automatic dev(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q);
		logic [31:0] r;
		// An interrupt-driven read may hold the reader; a command then would be lost.
		do ahb(1'b0, 32'h48, 32'h0, r); while (r[0] !== 1'b0);
		ahb(1'b1, 32'h48, {w, 7'h00, a, d}, r);
		do ahb(1'b0, 32'h48, 32'h0, r); while (r[0] !== 1'b0);
		ahb(1'b0, 32'h50, 32'h0, r);
		q = r[15:0];
	endtask : dev
	task automatic ev(input logic [3:0] l);
		eoc_event <= l;
		sample_data <= 12'($urandom);
		@(posedge ref_clk);
		eoc_event <= 4'h0;
		@(posedge ref_clk);
	endtask : ev
	// Main sequence.
	initial begin
		logic [15:0] q;
		logic [31:0] r;
		int n;
		time t0;
		void'($urandom(32'he9ab7041));
		{rst_n, htrans, haddr, hwrite, hwdata, eoc_event, sample_data} = '0;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		ahb(1'b0, 32'h4c, 32'h0, r);
		chk(r, 32'h1, "order reset");
		dev(1'b0, `ACD_ADDR_CTL2, 16'h0, q);
		chk(q, `ACD_CTL2_RESET, "ctl2 reset");
		dev(1'b1, `ACD_ADDR_CLR, 16'hf, q);
		dev(1'b0, `ACD_ADDR_CLR, 16'h0, q);
		chk(q, 32'h0, "clear reads");
		dev(1'b0, 8'h20, 16'h0, q);
		chk(q, 32'h0, "unmapped");
		$display("reset test done");
		for (int c = 0; c < 4; c++) begin
			dev(1'b1, `ACD_ADDR_CTL2, 16'(c), q);
			@(posedge cclk);
			t0 = $time;
			repeat (2) @(posedge cclk);
			chk(32'($time - t0), 32'(40 * (c + 2)), "divider");
		end
		$display("divider test done");
		for (int m = 0; m < 2; m++) begin
			dev(1'b1, `ACD_ADDR_CONT, {12'h0, {4{m[0]}}}, q);
			for (int l = 0; l < 4; l++) begin
				n = pc;
				ev(4'h1 << l);
				ev(4'h1 << l);
				repeat (8) @(posedge ref_clk);
				chk(32'(pc - n), 32'(1 + m), "pulses");
				dev(1'b0, `ACD_ADDR_OVF, 16'h0, q);
				chk(q[l], 1'b1, "overflow");
				dev(1'b1, `ACD_ADDR_CLR, 16'h1 << l, q);
				dev(1'b0, `ACD_ADDR_OVF, 16'h0, q);
				chk(q[3:0], 4'h0, "overflow cleared");
			end
		end
		$display("flag test done");
		dev(1'b1, `ACD_ADDR_CONT, 16'h0, q);
		ev(4'h1);
		fork
			dev(1'b1, `ACD_ADDR_CLR, 16'h1, q);
			begin
				do @(posedge ref_clk); while (acd_reader_inst.cmd_go !== 1'b1);
				eoc_event <= 4'h1;
				@(posedge ref_clk);
				eoc_event <= 4'h0;
			end
		join
		dev(1'b0, `ACD_ADDR_FLAG, 16'h0, q);
		chk(q[0], 1'b1, "set wins");
		n = pc;
		ev(4'h1);
		repeat (8) @(posedge ref_clk);
		chk(32'(pc - n), 32'h0, "still blocked");
		dev(1'b1, `ACD_ADDR_CLR, 16'h1, q);
		dev(1'b0, `ACD_ADDR_OVF, 16'h0, q);
		if (q[0] === 1'b1)
			dev(1'b1, `ACD_ADDR_CLR, 16'h1, q);
		dev(1'b0, `ACD_ADDR_FLAG, 16'h0, q);
		chk(q[0], 1'b0, "flag cleared");
		$display("race test done");
		dev(1'b1, `ACD_ADDR_CONT, 16'hf, q);
		for (int k = 0; k < 4; k++) begin
			dev(1'b1, `ACD_ADDR_CTL2, k[1] ? 16'h4 : 16'h0, q);
			dev(1'b1, `ACD_ADDR_LATE, 16'(k[0]), q);
			ev(4'h1);
			repeat (40) @(posedge ref_clk);
			ahb(1'b0, 32'h50, 32'h0, r);
			chk(r[11:0], sample_data, "fresh result");
		end
		// Without the dummy read, late mode and a slow divider give the old result.
		ahb(1'b1, 32'h4c, 32'h0, r);
		q = {4'h0, sample_data};
		ev(4'h1);
		repeat (40) @(posedge ref_clk);
		ahb(1'b0, 32'h50, 32'h0, r);
		chk(r[11:0], q[11:0], "stale result");
		ahb(1'b1, 32'h4c, 32'h1, r);
		ahb(1'b1, 32'h44, 32'h0, r);
		ahb(1'b1, 32'h40, 32'h3, r);
		ev(4'h1);
		repeat (40) @(posedge ref_clk);
		chk(irq, 1'b0, "irq masked");
		ahb(1'b1, 32'h44, 32'h2, r);
		@(posedge ref_clk);
		chk(irq, 1'b1, "irq raised");
		ahb(1'b1, 32'h40, 32'h3, r);
		@(posedge ref_clk);
		chk(irq, 1'b0, "irq cleared");
		$display("result and irq test done");
		tally_and_finish();
	end
	// Cuts a hang short.
	initial begin
		repeat (40000) @(posedge ref_clk);
		err_total++;
		$display("mismatch at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule : acd_tb_top
